// ==== rtl/lcfp_pkg.sv ====
// Function
// - undervoltage or enable low forces shutdown
// - bits 12:10 pick short drain threshold
// - bits 13,15 set: shorted channel switched off
// - bits 13,14,15 set: shorted channel retried
// - retry interval one millisecond per count
// - bits 9:8 pick short count 1/6/11/15
// - bit 6 enables open detection
// - bit 7 enables open retry behaviour
// - bits 6,5 set: open channel latched off
// - bits 6,7 set: open channel DAC maximum
// - over-temperature pulls fault pin low
// - bit 3 clear: no over-temperature shutoff
// - bit 3 set: over-temperature switches current off
// - serial data out released unless driving data
// - forty channels checked independently
package lcfp_pkg;
   localparam int          LCFP_NUM_CH       = 40;
   localparam logic [7:0]  LCFP_ADDR_CFG     = 8'h5d;
   localparam logic [7:0]  LCFP_ADDR_RETRY   = 8'h75;
   localparam logic [7:0]  LCFP_ADDR_STAT    = 8'h64;
   localparam logic [7:0]  LCFP_ADDR_CURON   = 8'h5e;
   localparam int          LCFP_SHORT_ARM    = 15;
   localparam int          LCFP_SHORT_RETRY  = 14;
   localparam int          LCFP_SHORT_EN     = 13;
   localparam int          LCFP_LVL_HI       = 12;
   localparam int          LCFP_LVL_LO       = 10;
   localparam int          LCFP_DEB_HI       = 9;
   localparam int          LCFP_DEB_LO       = 8;
   localparam int          LCFP_OPEN_RETRY   = 7;
   localparam int          LCFP_OPEN_EN      = 6;
   localparam int          LCFP_OPEN_AUTO    = 5;
   localparam int          LCFP_OTP_OFF      = 3;
   localparam int          LCFP_STAT_SHORT   = 0;
   localparam int          LCFP_STAT_OPEN    = 1;
   localparam int          LCFP_STAT_OTP     = 4;
   localparam logic [15:0] LCFP_CFG_RST      = 16'h0000;
   localparam logic [10:0] LCFP_RETRY_RST    = 11'h000;
   localparam logic        LCFP_CURON_RST    = 1'b0;
   localparam logic [3:0]  LCFP_DEB_1        = 4'h1;
   localparam logic [3:0]  LCFP_DEB_6        = 4'h6;
   localparam logic [3:0]  LCFP_DEB_11       = 4'hb;
   localparam logic [3:0]  LCFP_DEB_15       = 4'hf;
   localparam int          LCFP_CMD_BITS     = 16;
   localparam int          LCFP_FRAME_BITS   = 32;
   localparam int          LCFP_CLK_NS       = 10;
   localparam int          LCFP_RETRY_UNIT_NS = 1_000_000;
   localparam int          LCFP_MS_CYC       = LCFP_RETRY_UNIT_NS / LCFP_CLK_NS;

   typedef enum logic [2:0] {
      LCFP_RUN   = 3'b001,
      LCFP_LATCH = 3'b010,
      LCFP_WAIT  = 3'b100
   } lcfp_ch_st_t;

   function automatic logic [3:0] lcfp_deb_need(input logic [1:0] sel);
      case (sel)
         2'b00:   return LCFP_DEB_1;
         2'b01:   return LCFP_DEB_6;
         2'b10:   return LCFP_DEB_11;
         default: return LCFP_DEB_15;
      endcase
   endfunction
endpackage

// ==== rtl/lcfp_chan.sv ====
`timescale 1ns/10ps
`default_nettype none
module lcfp_chan
   import lcfp_pkg::*;
(
   // clock, reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // control from the top
   input  wire logic        clr_i,
   input  wire logic        kill_i,
   input  wire logic        ms_tick_i,
   input  wire logic [15:0] cfg_i,
   input  wire logic [10:0] retry_i,
   input  wire logic [3:0]  need_i,
   // channel sense
   input  wire logic        pwm_on_i,
   input  wire logic        short_i,
   input  wire logic        open_i,
   // results
   output logic             off_o,
   output logic             dac_max_o,
   output logic             short_flt_o,
   output logic             open_flt_o
);
   typedef struct packed {
      lcfp_ch_st_t st;
      logic [3:0]  cnt;
      logic [10:0] timer;
      logic        seen;
      logic        pon_d;
      logic        why_open;
      logic        off;
      logic        dmax;
   } lcfp_chan_st_t;

   lcfp_chan_st_t q_reg, q_next;
   logic short_en, short_rty, open_en, open_auto, open_rty, pon_end;

   assign short_en  = cfg_i[LCFP_SHORT_ARM] & cfg_i[LCFP_SHORT_EN];
   assign short_rty = short_en & cfg_i[LCFP_SHORT_RETRY];
   assign open_en   = cfg_i[LCFP_OPEN_EN];
   assign open_auto = open_en & cfg_i[LCFP_OPEN_AUTO];
   assign open_rty  = open_en & cfg_i[LCFP_OPEN_RETRY];
   assign pon_end   = q_reg.pon_d & ~pwm_on_i;

   always_comb begin
      q_next = q_reg;
      q_next.pon_d = pwm_on_i;
      if (clr_i) begin
         q_next.st   = LCFP_RUN;
         q_next.cnt  = 4'h0;
         q_next.seen = 1'b0;
         q_next.timer = 11'h000;
      end else begin
         case (q_reg.st)
            LCFP_RUN: begin
               if (pwm_on_i && short_i && short_en) begin
                  q_next.seen = 1'b1;
               end
               if (pon_end) begin
                  q_next.seen = 1'b0;
                  if (q_reg.seen) begin
                     if (5'(q_reg.cnt) + 5'h01 >= 5'(need_i)) begin
                        q_next.cnt = 4'h0;
                        q_next.why_open = 1'b0;
                        q_next.timer = retry_i;
                        q_next.st = short_rty ? LCFP_WAIT : LCFP_LATCH;
                     end else begin
                        q_next.cnt = q_reg.cnt + 4'h1;
                     end
                  end else begin
                     q_next.cnt = 4'h0;
                  end
               end
               // open latch wins over a short decision in the same cycle
               if (open_auto && open_i && pwm_on_i) begin
                  q_next.st = LCFP_LATCH;
                  q_next.why_open = 1'b1;
               end
            end
            LCFP_LATCH: q_next.st = LCFP_LATCH;
            LCFP_WAIT: begin
               // zero interval re-enables on the next cycle
               if (q_reg.timer == 11'h000) begin
                  q_next.st = LCFP_RUN;
                  q_next.seen = 1'b0;
               end else if (ms_tick_i) begin
                  q_next.timer = q_reg.timer - 11'h001;
               end
            end
            default: q_next.st = LCFP_RUN;
         endcase
      end
      q_next.off  = kill_i | (q_next.st != LCFP_RUN);
      q_next.dmax = open_rty & open_i;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         // sinks stay off while reset is held, the shutdown path takes over after release
         q_reg <= '{st: LCFP_RUN, off: 1'b1, default: '0};
      end else begin
         q_reg <= q_next;
      end
   end

   assign off_o       = q_reg.off;
   assign dac_max_o   = q_reg.dmax;
   assign short_flt_o = (q_reg.st != LCFP_RUN) & ~q_reg.why_open;
   assign open_flt_o  = (q_reg.st != LCFP_RUN) & q_reg.why_open;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   short_latch_a: assert property ((q_reg.st == LCFP_LATCH) && !clr_i |=> off_o)
      else $error("latched channel not off");
   retry_wait_a: assert property ((q_reg.st == LCFP_WAIT) && q_reg.timer != 11'h000 && !clr_i
                                  |=> q_reg.st == LCFP_WAIT)
      else $error("retry left before interval");
   open_latch_a: assert property ((q_reg.st == LCFP_RUN) && open_auto && open_i && pwm_on_i && !clr_i
                                  |=> q_reg.st == LCFP_LATCH ##1 off_o)
      else $error("open channel not latched off");
   dac_max_a: assert property (open_en && cfg_i[LCFP_OPEN_RETRY] && open_i |=> dac_max_o)
      else $error("open retry without max dac");
   count_reset_a: assert property ((q_reg.st == LCFP_RUN) && pon_end && !q_reg.seen && !clr_i
                                   |=> q_reg.cnt == 4'h0)
      else $error("short count kept after clean period");
   run_on_a: assert property (!kill_i && q_next.st == LCFP_RUN |=> !off_o)
      else $error("running channel switched off");
   retry_cyc_c: cover property ((q_reg.st == LCFP_WAIT) ##1 (q_reg.st == LCFP_RUN));
   open_latch_c: cover property (q_reg.st == LCFP_LATCH && q_reg.why_open);
endmodule
`default_nettype wire

// ==== rtl/lcfp_protect.sv ====
`timescale 1ns/10ps
`default_nettype none
module lcfp_protect
   import lcfp_pkg::*;
#(
   parameter int unsigned MS_CYCLES = LCFP_MS_CYC
)(
   // clock, reset
   input  wire logic                   mclk_i,
   input  wire logic                   rst_i,
   // power and temperature sense pins
   input  wire logic                   en_i,
   input  wire logic                   uvlo_i,
   input  wire logic                   otp_i,
   // serial port
   input  wire logic                   serial_select_n_i,
   input  wire logic                   spi_clk_i,
   input  wire logic                   sdi_i,
   output logic                        sdo_o,
   output logic                        sdo_oe_o,
   // open-drain fault pin
   output logic                        fault_o,
   output logic                        fault_oe_o,
   // channel sense
   input  wire logic [LCFP_NUM_CH-1:0] pwm_on_i,
   input  wire logic [LCFP_NUM_CH-1:0] short_det_i,
   input  wire logic [LCFP_NUM_CH-1:0] open_det_i,
   // channel control
   output logic [LCFP_NUM_CH-1:0]      ch_off_o,
   output logic [LCFP_NUM_CH-1:0]      dac_max_o,
   output logic [2:0]                  short_level_o,
   output logic                        shutdown_o
);
   typedef struct packed {
      logic                   cs1, cs2;
      logic                   ck1, ck2, ck3;
      logic                   di1, di2;
      logic                   en1, en2;
      logic                   uv1, uv2;
      logic                   ot1, ot2;
      logic [LCFP_NUM_CH-1:0] sh1, sh2;
      logic [LCFP_NUM_CH-1:0] op1, op2;
      logic [5:0]             bitcnt;
      logic [15:0]            shreg;
      logic [15:0]            obuf;
      logic                   rd;
      logic [7:0]             addr;
      logic                   sdo;
      logic                   sdo_oe;
      logic [15:0]            cfg;
      logic [10:0]            rtry;
      logic                   curon;
      logic [16:0]            div;
      logic                   tick;
      logic                   foe;
      logic                   fo;
      logic                   shut;
   } lcfp_top_st_t;

   lcfp_top_st_t q_reg, q_next;

   logic                   clr, kill, any_s, any_o, rise, fall;
   logic [3:0]             need;
   logic [7:0]             cmd_addr;
   logic [15:0]            word;
   logic [LCFP_NUM_CH-1:0] ch_short, ch_open;

   function automatic logic [15:0] rd_mux(input logic [7:0]  a,
                                         input logic [15:0] c,
                                         input logic [10:0] r,
                                         input logic        on,
                                         input logic        ot,
                                         input logic        fs,
                                         input logic        fo);
      logic [15:0] d;
      d = 16'h0000;
      case (a)
         LCFP_ADDR_CFG:   d = c;
         LCFP_ADDR_RETRY: d = {5'h00, r};
         LCFP_ADDR_CURON: d = {15'h0000, on};
         LCFP_ADDR_STAT: begin
            d[LCFP_STAT_SHORT] = fs;
            d[LCFP_STAT_OPEN]  = fo;
            d[LCFP_STAT_OTP]   = ot;
         end
         default: d = 16'h0000;
      endcase
      return d;
   endfunction

   // edges taken from the second and third stages, never the first
   assign rise     = q_reg.ck2 & ~q_reg.ck3;
   assign fall     = ~q_reg.ck2 & q_reg.ck3;
   assign word     = {q_reg.shreg[14:0], q_reg.di2};
   assign cmd_addr = word[7:0];
   assign any_s    = |ch_short;
   assign any_o    = |ch_open;
   assign need     = lcfp_deb_need(q_reg.cfg[LCFP_DEB_HI:LCFP_DEB_LO]);
   assign clr      = q_reg.shut | ~q_reg.curon;
   assign kill     = clr | (q_reg.ot2 & q_reg.cfg[LCFP_OTP_OFF]);

   always_comb begin
      q_next = q_reg;
      q_next.cs1 = serial_select_n_i;
      q_next.cs2 = q_reg.cs1;
      q_next.ck1 = spi_clk_i;
      q_next.ck2 = q_reg.ck1;
      q_next.ck3 = q_reg.ck2;
      q_next.di1 = sdi_i;
      q_next.di2 = q_reg.di1;
      q_next.en1 = en_i;
      q_next.en2 = q_reg.en1;
      q_next.uv1 = uvlo_i;
      q_next.uv2 = q_reg.uv1;
      q_next.ot1 = otp_i;
      q_next.ot2 = q_reg.ot1;
      q_next.sh1 = short_det_i;
      q_next.sh2 = q_reg.sh1;
      q_next.op1 = open_det_i;
      q_next.op2 = q_reg.op1;
      q_next.shut = ~q_reg.en2 | q_reg.uv2;
      q_next.foe  = q_reg.ot2;
      q_next.fo   = 1'b0;
      q_next.tick = 1'b0;
      if (q_reg.div == 17'(MS_CYCLES - 1)) begin
         q_next.div  = 17'h0_0000;
         q_next.tick = 1'b1;
      end else begin
         q_next.div = q_reg.div + 17'h0_0001;
      end
      if (q_reg.shut) begin
         // shutdown drops every setting, the host reprograms after standby
         q_next.cfg    = LCFP_CFG_RST;
         q_next.rtry   = LCFP_RETRY_RST;
         q_next.curon  = LCFP_CURON_RST;
         q_next.bitcnt = 6'h00;
         q_next.rd     = 1'b0;
         q_next.sdo_oe = 1'b0;
      end else if (q_reg.cs2) begin
         q_next.bitcnt = 6'h00;
         q_next.rd     = 1'b0;
         q_next.sdo_oe = 1'b0;
      end else begin
         if (rise && q_reg.bitcnt < 6'(LCFP_FRAME_BITS)) begin
            q_next.shreg  = word;
            q_next.bitcnt = q_reg.bitcnt + 6'h01;
            if (q_reg.bitcnt == 6'(LCFP_CMD_BITS - 1)) begin
               q_next.rd   = word[15];
               q_next.addr = cmd_addr;
               q_next.obuf = rd_mux(cmd_addr, q_reg.cfg, q_reg.rtry, q_reg.curon,
                                    q_reg.ot2, any_s, any_o);
            end
            if (q_reg.bitcnt == 6'(LCFP_FRAME_BITS - 1) && !q_reg.rd) begin
               case (q_reg.addr)
                  LCFP_ADDR_CFG:   q_next.cfg   = word;
                  LCFP_ADDR_RETRY: q_next.rtry  = word[10:0];
                  LCFP_ADDR_CURON: q_next.curon = word[0];
                  default:         q_next.cfg   = q_reg.cfg;
               endcase
            end
         end
         if (fall && q_reg.rd && q_reg.bitcnt >= 6'(LCFP_CMD_BITS)) begin
            q_next.sdo    = q_reg.obuf[15];
            q_next.obuf   = {q_reg.obuf[14:0], 1'b0};
            q_next.sdo_oe = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         q_reg <= '{cs1: 1'b1, cs2: 1'b1, shut: 1'b1, default: '0};
      end else begin
         q_reg <= q_next;
      end
   end

   for (genvar g = 0; g < LCFP_NUM_CH; g++) begin : g_ch
      lcfp_chan u_chan (
         .mclk_i      (mclk_i),
         .rst_i       (rst_i),
         .clr_i       (clr),
         .kill_i      (kill),
         .ms_tick_i   (q_reg.tick),
         .cfg_i       (q_reg.cfg),
         .retry_i     (q_reg.rtry),
         .need_i      (need),
         .pwm_on_i    (pwm_on_i[g]),
         .short_i     (q_reg.sh2[g]),
         .open_i      (q_reg.op2[g]),
         .off_o       (ch_off_o[g]),
         .dac_max_o   (dac_max_o[g]),
         .short_flt_o (ch_short[g]),
         .open_flt_o  (ch_open[g])
      );
   end

   assign sdo_o         = q_reg.sdo;
   assign sdo_oe_o      = q_reg.sdo_oe;
   assign fault_o       = q_reg.fo;
   assign fault_oe_o    = q_reg.foe;
   assign short_level_o = q_reg.cfg[LCFP_LVL_HI:LCFP_LVL_LO];
   assign shutdown_o    = q_reg.shut;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   shut_off_a: assert property (q_reg.shut |=> ch_off_o == '1)
      else $error("channel on during shutdown");
   otp_off_a: assert property (q_reg.ot2 && q_reg.cfg[LCFP_OTP_OFF] |=> ch_off_o == '1)
      else $error("channel on during over-temperature");
   fault_pin_a: assert property ($rose(q_reg.ot2) |=> fault_oe_o && !fault_o)
      else $error("fault pin not pulled low");
   sdo_hiz_a: assert property (q_reg.cs2 |=> !sdo_oe_o)
      else $error("serial out driven while deselected");
   spi_read_c: cover property (q_reg.sdo_oe && q_reg.rd);
   otp_shut_c: cover property (q_reg.ot2 && q_reg.cfg[LCFP_OTP_OFF]);
endmodule
`default_nettype wire

// ==== tb/lcfp_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module lcfp_host_model (
   // clock
   input  wire logic mclk_i,
   // serial port
   output logic      serial_select_n_o,
   output logic      spi_clk_o,
   output logic      sdi_o,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i
);
   logic last_bit;
   logic sdo_line;
   // a released data line shows the inverse of its last driven bit, never a stale copy
   assign sdo_line = sdo_oe_i ? sdo_i : ~last_bit;
   initial begin
      serial_select_n_o = 1'b1;
      spi_clk_o = 1'b0;
      sdi_o = 1'b0;
      last_bit = 1'b0;
   end
   // six clocks a level keeps the serial clock well under the sampling limit
   task automatic half();
      repeat (6) @(posedge mclk_i);
      #1;
   endtask
   task automatic xfer(input logic [31:0] frame, output logic [15:0] rd, output logic oe_ok);
      int i;
      rd = 16'h0000;
      oe_ok = 1'b1;
      serial_select_n_o = 1'b0;
      for (i = 31; i >= 0; i--) begin
         sdi_o = frame[i];
         half();
         spi_clk_o = 1'b1;
         if (i < 16 && frame[31]) begin
            rd[i] = sdo_line;
            oe_ok = oe_ok & (sdo_oe_i === 1'b1);
         end
         if (sdo_oe_i === 1'b1) begin
            last_bit = sdo_i;
         end
         half();
         spi_clk_o = 1'b0;
      end
      half();
      serial_select_n_o = 1'b1;
      half();
      oe_ok = oe_ok & (sdo_oe_i === 1'b0);
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import lcfp_pkg::*;
   logic mclk_i, rst_i, en_i, uvlo_i, otp_i;
   logic cs_n, sclk, sdi, sdo, sdo_oe, fault, fault_oe, shut;
   logic [39:0] pwm, short_det, open_det, ch_off, dac_max, seen_max;
   logic [2:0]  level;
   logic [15:0] rdat;
   logic        ok;
   int          error_cnt, check_count, ch, n, cnt;
   logic [15:0] v;

   lcfp_protect #(.MS_CYCLES(10)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .en_i(en_i), .uvlo_i(uvlo_i),
      .otp_i(otp_i), .serial_select_n_i(cs_n), .spi_clk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
      .sdo_oe_o(sdo_oe), .fault_o(fault), .fault_oe_o(fault_oe), .pwm_on_i(pwm),
      .short_det_i(short_det), .open_det_i(open_det), .ch_off_o(ch_off), .dac_max_o(dac_max),
      .short_level_o(level), .shutdown_o(shut));
   lcfp_host_model host (.mclk_i(mclk_i), .serial_select_n_o(cs_n), .spi_clk_o(sclk), .sdi_o(sdi),
      .sdo_i(sdo), .sdo_oe_i(sdo_oe));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   function automatic int need(input int sel);
      return (sel == 0) ? 1 : (sel == 1) ? 6 : (sel == 2) ? 11 : 15;
   endfunction
   task automatic clk(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host.xfer({8'h00, a, d}, rdat, ok);
      clk(4);
   endtask
   task automatic rd(input logic [7:0] a);
      host.xfer({8'h80, a, 16'h0000}, rdat, ok);
      cmp({39'h0, ok}, 40'h1, "sdo drive window");
   endtask
   // channel current is dropped while the settings change, so no half-set mode is ever live
   task automatic setup(input logic [15:0] c);
      wr(LCFP_ADDR_CURON, 16'h0000);
      wr(LCFP_ADDR_CFG, c);
      wr(LCFP_ADDR_CURON, 16'h0001);
   endtask
   task automatic period(input logic sh, input logic op);
      short_det[ch] = sh;
      open_det[ch] = op;
      clk(3);
      pwm = '1;
      clk(6);
      seen_max = dac_max;
      pwm = '0;
      clk(4);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_run();
      cnt = 0;
      while (shut !== 1'b0 && cnt < 20) begin
         clk(1);
         cnt++;
      end
      if (cnt >= 20) begin
         cmp(40'h0, 40'h1, "shutdown never released");
         results();
      end
      clk(20);
   endtask

   initial begin
      void'($urandom(60478));
      {rst_i, en_i, uvlo_i, otp_i} = 4'b1100;
      {pwm, short_det, open_det} = '0;
      clk(12);
      rst_i = 1'b0;
      wait_run();
      rd(LCFP_ADDR_CFG);   cmp(rdat, LCFP_CFG_RST, "cfg reset");
      rd(LCFP_ADDR_RETRY); cmp(rdat, 16'h0000, "retry reset");
      wr(8'h33, 16'hffff);
      rd(8'h33);           cmp(rdat, 16'h0000, "unmapped read");
      for (int i = 0; i < 8; i++) begin
         v = 16'($urandom) & 16'he3ff | 16'(i << 10);
         wr(LCFP_ADDR_CFG, v);
         rd(LCFP_ADDR_CFG); cmp(rdat, v, "cfg readback");
         cmp(level, v[12:10], "short level");
         wr(LCFP_ADDR_RETRY, ~v);
         rd(LCFP_ADDR_RETRY); cmp(rdat, ~v & 16'h07ff, "retry readback");
      end
      for (int sel = 0; sel < 4; sel++) begin
         n = need(sel);
         ch = $urandom_range(39);
         setup(16'ha000 | 16'(sel << 8));
         repeat (n - 1) period(1'b1, 1'b0);
         period(1'b0, 1'b0);
         repeat (n - 1) period(1'b1, 1'b0);
         cmp(ch_off, 40'h0, "short count early");
         period(1'b1, 1'b0);
         cmp(ch_off, 40'h1 << ch, "short off one channel");
         rd(LCFP_ADDR_STAT); cmp(rdat[0], 1'b1, "short status");
         short_det = '0;
      end
      wr(LCFP_ADDR_RETRY, 16'h0003);
      setup(16'he000);
      period(1'b1, 1'b0);
      short_det = '0;
      cmp(ch_off[ch], 1'b1, "retry off");
      cnt = 0;
      while (ch_off[ch] !== 1'b0 && cnt < 60) begin
         clk(1);
         cnt++;
      end
      cmp({39'h0, cnt >= 15 && cnt <= 32}, 40'h1, "retry interval");
      period(1'b1, 1'b0);
      cmp(ch_off[ch], 1'b1, "retry re-evaluated");
      short_det = '0;
      setup(16'h0060);
      period(1'b0, 1'b1);
      cmp(ch_off, 40'h1 << ch, "open off");
      period(1'b0, 1'b0);
      cmp(ch_off[ch], 1'b1, "open latched");
      rd(LCFP_ADDR_STAT); cmp(rdat[1], 1'b1, "open status");
      setup(16'h0020);
      period(1'b0, 1'b1);
      cmp(ch_off, 40'h0, "open detect disabled");
      setup(16'h00c0);
      period(1'b0, 1'b1);
      cmp(seen_max, 40'h1 << ch, "open dac max");
      period(1'b0, 1'b0);
      cmp(seen_max, 40'h0, "dac max released");
      setup(16'h0080);
      period(1'b0, 1'b1);
      cmp(seen_max, 40'h0, "retry without detect");
      open_det = '0;
      for (int k = 0; k < 2; k++) begin
         setup(16'h0008 * k);
         otp_i = 1'b1;
         clk(6);
         cmp({fault_oe, fault}, 2'b10, "fault pin low");
         cmp(ch_off, k ? {40{1'b1}} : 40'h0, "otp current");
         rd(LCFP_ADDR_STAT); cmp(rdat[4], 1'b1, "otp status");
         otp_i = 1'b0;
         clk(6);
         cmp(fault_oe, 1'b0, "fault pin released");
      end
      for (int k = 0; k < 2; k++) begin
         // a non-zero setting beforehand, so that the clear below can be seen
         wr(LCFP_ADDR_CFG, 16'h5a5a);
         if (k == 0) uvlo_i = 1'b1; else en_i = 1'b0;
         clk(6);
         cmp(shut, 1'b1, "shutdown entered");
         {en_i, uvlo_i} = 2'b10;
         wait_run();
         rd(LCFP_ADDR_CFG); cmp(rdat, 16'h0000, "cfg cleared by shutdown");
      end
      results();
   end
endmodule
`default_nettype wire
